// ===== rtl/hc_ctrl_pkg.sv
// Shared constants and types for the host controller operational control registers
package hc_ctrl_pkg;

	// ----------------------------------------------------------------
	// Register map (byte offsets within the 4 KB operational window)
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_SPEC_REVISION  = 12'h000;
	localparam logic [11:0] OFS_HOST_OP_CTRL   = 12'h004;
	localparam int          WINDOW_LSB         = 12;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int          POS_RATIO          = 0;
	localparam int          POS_PERIODIC_EN    = 2;
	localparam int          POS_ISO_KEEP       = 3;
	localparam int          POS_CONTROL_EN     = 4;
	localparam int          POS_BULK_EN        = 5;
	localparam int          POS_FUNC_STATE     = 6;
	localparam int          POS_IRQ_TO_SMI     = 8;
	localparam int          POS_RWAKE_CONN     = 9;
	localparam int          POS_RWAKE_EN       = 10;
	localparam logic [31:0] CTRL_RESET         = 32'h0000_0000;
	// Arbitrary revision value, not a real part's
	localparam logic [7:0]  REVISION_DEFAULT   = 8'h2A;
	localparam logic [31:0] READ_ZERO          = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		FS_USB_RESET   = 2'h0,
		FS_USB_RESUME  = 2'h1,
		FS_USB_OPER    = 2'h2,
		FS_USB_SUSPEND = 2'h3
	} func_state_t;

	typedef struct packed
	{
		logic        rwake_en;
		logic        irq_to_smi;
		func_state_t func_state;
		logic        bulk_en;
		logic        control_en;
		logic        iso_keep;
		logic        periodic_en;
		logic [1:0]  ratio;
	} ctrl_t;

	typedef struct packed
	{
		logic        valid;
		logic        write;
		logic [31:0] addr;
		logic [3:0]  be_n;
		logic [31:0] wdata;
	} mem_req_t;

	typedef struct packed
	{
		logic        valid;
		logic        hit;
		logic [31:0] rdata;
	} mem_rsp_t;

endpackage

// ===== rtl/service_ratio.sv
// Control-to-bulk service ratio sequencer
`timescale 1ns/1ns
module service_ratio
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// Ratio setting, count minus one
	input  wire logic [1:0] ratio,
	// Service events from the list engine
	input  wire logic       control_served,
	input  wire logic       bulk_served,
	// Turn indication
	output logic            bulk_turn
);

	logic [1:0] served_q;
	logic [1:0] served_d;
	logic       turn_q;
	logic       turn_d;

	// ----------------------------------------------------------------
	// Counting
	// ----------------------------------------------------------------
	always_comb
	begin
		served_d = served_q;
		turn_d   = turn_q;
		if (turn_q && bulk_served)
		begin
			turn_d   = 1'b0;
			served_d = 2'h0;
		end
		else if (!turn_q && control_served)
		begin
			// ratio 00 gives one control endpoint, 11 gives four [RULE_07]
			if (served_q >= ratio)
			begin
				turn_d   = 1'b1;
				served_d = 2'h0;
			end
			else
				served_d = served_q + 2'h1;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			served_q <= 2'h0;
			turn_q   <= 1'b0;
		end
		else
		begin
			served_q <= served_d;
			turn_q   <= turn_d;
		end
	end

	assign bulk_turn = turn_q;

endmodule

// ===== rtl/usb_host_operational_control_regs.sv
// Host controller operational registers: revision and operation control
//
// What this block does
// RULE_01: The registers are decoded as memory locations at offsets from the programmed base.
// RULE_02: Each 32-bit register is byte addressable, little endian, byte 0 holding bits 7 to 0.
// RULE_03: The revision register is read-only, low byte major/minor nibbles, upper bits zero.
// RULE_04: Control bits 7:6 hold the functional state, and suspend moves to resume on resume.
// RULE_05: Control bits 5, 4 and 2 enable bulk, control and periodic list processing.
// RULE_06: Isochronous descriptors are skipped per control bit 3, interrupt ones still served.
// RULE_07: Control bits 1:0 give control endpoints per bulk endpoint as count minus one.
// RULE_08: The remote wakeup enable bit is writable but has no effect.
// RULE_09: The remote wakeup connected bit is read-only and always zero.
// RULE_10: Control bit 8 steers interrupts to the normal line when 0, to SMI when 1.
// RULE_11: Reserved control bits read zero, and all control fields clear on reset.
`timescale 1ns/1ns
module usb_host_operational_control_regs
#(
	// Arbitrary revision value, not a real part's
	parameter logic [7:0] REVISION = hc_ctrl_pkg::REVISION_DEFAULT
)
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  resetn,
	// Memory base from the configuration space
	input  wire logic [31:12]          mem_base,
	// Memory cycle request and answer
	input  wire hc_ctrl_pkg::mem_req_t mem_req,
	output hc_ctrl_pkg::mem_rsp_t      mem_rsp,
	// Events from port and list logic
	input  wire logic                  resume_detect,
	input  wire logic                  frame_start,
	input  wire logic                  iso_desc_seen,
	input  wire logic                  control_served,
	input  wire logic                  bulk_served,
	input  wire logic                  core_irq,
	// Control outputs toward the schedule engine
	output hc_ctrl_pkg::func_state_t   func_state,
	output logic                       bulk_list_go,
	output logic                       control_list_go,
	output logic                       periodic_go,
	output logic                       iso_skip,
	output logic                       bulk_turn,
	// Interrupt delivery
	output logic                       inta_req,
	output logic                       smi_req
);

	hc_ctrl_pkg::ctrl_t    ctrl_q;
	hc_ctrl_pkg::ctrl_t    ctrl_d;
	hc_ctrl_pkg::mem_rsp_t rsp_q;
	hc_ctrl_pkg::mem_rsp_t rsp_d;
	logic                  periodic_q;
	logic                  periodic_d;
	logic                  skip_q;
	logic                  skip_d;
	logic                  inta_q;
	logic                  inta_d;
	logic                  smi_q;
	logic                  smi_d;
	logic                  bulk_turn_w;
	logic                  in_window;
	logic                  hit_rev;
	logic                  hit_ctrl;
	logic [31:0]           ctrl_word;
	logic [31:0]           wr_mask;
	logic [31:0]           merged;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	assign in_window = mem_req.valid
		&& (mem_req.addr[31:hc_ctrl_pkg::WINDOW_LSB] == mem_base);   // [RULE_01]
	assign hit_rev   = in_window
		&& (mem_req.addr[11:2] == hc_ctrl_pkg::OFS_SPEC_REVISION[11:2]);
	assign hit_ctrl  = in_window
		&& (mem_req.addr[11:2] == hc_ctrl_pkg::OFS_HOST_OP_CTRL[11:2]);

	// Reserved bits and the wakeup-connected bit always read zero
	always_comb
	begin
		ctrl_word = hc_ctrl_pkg::READ_ZERO;                           // [RULE_11]
		ctrl_word[hc_ctrl_pkg::POS_RATIO +: 2]      = ctrl_q.ratio;
		ctrl_word[hc_ctrl_pkg::POS_PERIODIC_EN]     = ctrl_q.periodic_en;
		ctrl_word[hc_ctrl_pkg::POS_ISO_KEEP]        = ctrl_q.iso_keep;
		ctrl_word[hc_ctrl_pkg::POS_CONTROL_EN]      = ctrl_q.control_en;
		ctrl_word[hc_ctrl_pkg::POS_BULK_EN]         = ctrl_q.bulk_en;
		ctrl_word[hc_ctrl_pkg::POS_FUNC_STATE +: 2] = ctrl_q.func_state;
		ctrl_word[hc_ctrl_pkg::POS_IRQ_TO_SMI]      = ctrl_q.irq_to_smi;
		ctrl_word[hc_ctrl_pkg::POS_RWAKE_CONN]      = 1'b0;            // [RULE_09]
		ctrl_word[hc_ctrl_pkg::POS_RWAKE_EN]        = ctrl_q.rwake_en;
	end

	// Byte lanes: lane 0 is bits 7:0, lane 3 is bits 31:24
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : gen_lane
			assign wr_mask[g*8 +: 8] = {8{~mem_req.be_n[g]}};             // [RULE_02]
		end
	endgenerate

	assign merged = (mem_req.wdata & wr_mask) | (ctrl_word & ~wr_mask);

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	always_comb
	begin
		ctrl_d = ctrl_q;
		if (hit_ctrl && mem_req.write)
		begin
			ctrl_d.ratio       = merged[hc_ctrl_pkg::POS_RATIO +: 2];       // [RULE_07]
			ctrl_d.periodic_en = merged[hc_ctrl_pkg::POS_PERIODIC_EN];     // [RULE_05]
			ctrl_d.iso_keep    = merged[hc_ctrl_pkg::POS_ISO_KEEP];        // [RULE_06]
			ctrl_d.control_en  = merged[hc_ctrl_pkg::POS_CONTROL_EN];      // [RULE_05]
			ctrl_d.bulk_en     = merged[hc_ctrl_pkg::POS_BULK_EN];         // [RULE_05]
			ctrl_d.func_state  = hc_ctrl_pkg::func_state_t'(
				merged[hc_ctrl_pkg::POS_FUNC_STATE +: 2]);                 // [RULE_04]
			ctrl_d.irq_to_smi  = merged[hc_ctrl_pkg::POS_IRQ_TO_SMI];      // [RULE_10]
			// Stored only; nothing downstream looks at it
			ctrl_d.rwake_en    = merged[hc_ctrl_pkg::POS_RWAKE_EN];        // [RULE_08]
		end
		// Hardware resume wins over a write that leaves the state in suspend
		if (resume_detect && ctrl_d.func_state == hc_ctrl_pkg::FS_USB_SUSPEND)
			ctrl_d.func_state = hc_ctrl_pkg::FS_USB_RESUME;                 // [RULE_04]
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			ctrl_q <= hc_ctrl_pkg::ctrl_t'(hc_ctrl_pkg::CTRL_RESET[9:0]); // [RULE_11]
		else
			ctrl_q <= ctrl_d;
	end

	// ----------------------------------------------------------------
	// Read answer, one cycle after the request
	// ----------------------------------------------------------------
	always_comb
	begin
		rsp_d.valid = mem_req.valid && !mem_req.write;
		rsp_d.hit   = (hit_rev || hit_ctrl) && !mem_req.write;
		rsp_d.rdata = hc_ctrl_pkg::READ_ZERO;
		if (hit_rev && !mem_req.write)
			rsp_d.rdata = {24'h00_0000, REVISION};                          // [RULE_03]
		else if (hit_ctrl && !mem_req.write)
			rsp_d.rdata = ctrl_word;                                        // [RULE_02]
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rsp_q <= '0;
		else
			rsp_q <= rsp_d;
	end

	// ----------------------------------------------------------------
	// Schedule steering and interrupt routing
	// ----------------------------------------------------------------
	// Periodic enable is sampled once per frame so a mid-frame change waits
	always_comb
	begin
		periodic_d = frame_start ? ctrl_q.periodic_en : periodic_q;     // [RULE_05]
		// Bit 3 clear means skip isochronous descriptors in the periodic list
		skip_d     = iso_desc_seen && periodic_q && !ctrl_q.iso_keep;   // [RULE_06]
		inta_d     = core_irq && !ctrl_q.irq_to_smi;                    // [RULE_10]
		smi_d      = core_irq && ctrl_q.irq_to_smi;                     // [RULE_10]
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			periodic_q <= 1'b0;
			skip_q     <= 1'b0;
			inta_q     <= 1'b0;
			smi_q      <= 1'b0;
		end
		else
		begin
			periodic_q <= periodic_d;
			skip_q     <= skip_d;
			inta_q     <= inta_d;
			smi_q      <= smi_d;
		end
	end

	service_ratio u_ratio
	(
		.clk            (clk),
		.resetn         (resetn),
		.ratio          (ctrl_q.ratio),
		.control_served (control_served),
		.bulk_served    (bulk_served),
		.bulk_turn      (bulk_turn_w)
	);                                                                   // [RULE_07]

	assign mem_rsp         = rsp_q;
	assign func_state      = ctrl_q.func_state;
	assign bulk_list_go    = ctrl_q.bulk_en;
	assign control_list_go = ctrl_q.control_en;
	assign periodic_go     = periodic_q;
	assign iso_skip        = skip_q;
	assign bulk_turn       = bulk_turn_w;
	assign inta_req        = inta_q;
	assign smi_req         = smi_q;

endmodule

// ===== test/ctrl_regs_sva.sv
// Port checker for the operation control register block
`timescale 1ns/1ns
module ctrl_regs_sva
#(
	parameter logic [7:0] REVISION = 8'h00
)
(
	// Clock and reset
	input wire logic                    clk,
	input wire logic                    resetn,
	// Memory cycles
	input wire logic [31:12]            mem_base,
	input wire hc_ctrl_pkg::mem_req_t   mem_req,
	input wire hc_ctrl_pkg::mem_rsp_t   mem_rsp,
	// Events
	input wire logic                    resume_detect,
	input wire logic                    frame_start,
	input wire logic                    iso_desc_seen,
	input wire logic                    control_served,
	input wire logic                    bulk_served,
	input wire logic                    core_irq,
	// Outputs under watch
	input wire hc_ctrl_pkg::func_state_t func_state,
	input wire logic                    bulk_list_go,
	input wire logic                    control_list_go,
	input wire logic                    periodic_go,
	input wire logic                    iso_skip,
	input wire logic                    bulk_turn,
	input wire logic                    inta_req,
	input wire logic                    smi_req
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	wire logic [3:0] wd_hi = mem_req.wdata[7:4];
	wire logic in_win = mem_req.valid && mem_req.addr[31:12] == mem_base;
	wire logic rd_any = mem_req.valid && !mem_req.write;
	wire logic wr_ctl = in_win && mem_req.write && mem_req.addr[11:2] == 10'h001;
	wire logic wr_all = wr_ctl && mem_req.be_n == 4'h0;
	wire logic wakes = func_state == hc_ctrl_pkg::FS_USB_SUSPEND && resume_detect;

	a_read_answer: assert property (rd_any |=> mem_rsp.valid)
		else $error("read got no answer");
	a_rev_value: assert property (rd_any && in_win && mem_req.addr[11:2] == 10'h000
		|=> mem_rsp.hit && mem_rsp.rdata == {24'h000000, REVISION})
		else $error("revision read wrong");
	a_miss_zero: assert property (rd_any
		&& !(in_win && mem_req.addr[11:3] == 9'h000)
		|=> !mem_rsp.hit && mem_rsp.rdata == 32'h0)
		else $error("miss returned data");
	a_rsvd_zero: assert property (mem_rsp.valid |-> mem_rsp.rdata[31:11] == 21'h0
		&& !mem_rsp.rdata[9])
		else $error("reserved bits not zero");
	a_write_ctrl: assert property (wr_all && !resume_detect
		|=> {func_state, bulk_list_go, control_list_go} == $past(wd_hi))
		else $error("control write not applied");
	a_resume_move: assert property (wakes && !wr_ctl
		|=> func_state == hc_ctrl_pkg::FS_USB_RESUME)
		else $error("no move to resume");
	a_periodic_hold: assert property (!frame_start |=> $stable(periodic_go))
		else $error("periodic enable moved mid frame");
	a_iso_cause: assert property (iso_skip |-> $past(iso_desc_seen) && $past(periodic_go))
		else $error("iso skip without cause");
	a_turn_hold: assert property (bulk_turn && !bulk_served |=> bulk_turn)
		else $error("bulk turn dropped");
	a_turn_clear: assert property (bulk_turn && bulk_served |=> !bulk_turn)
		else $error("bulk turn stuck");
	a_irq_route: assert property (inta_req || smi_req |-> $past(core_irq)
		&& !(inta_req && smi_req))
		else $error("interrupt routing wrong");
	a_reset_zero: assert property ($rose(resetn)
		|-> func_state == hc_ctrl_pkg::FS_USB_RESET
		&& !bulk_list_go && !control_list_go && !periodic_go
		&& !bulk_turn && !iso_skip)
		else $error("control not cleared by reset");

	cover property (func_state == hc_ctrl_pkg::FS_USB_RESUME);
	cover property (iso_skip);
	cover property (smi_req);
	cover property (bulk_turn && bulk_served);
endmodule

bind usb_host_operational_control_regs ctrl_regs_sva #(.REVISION(REVISION)) ctrl_regs_sva_i
(
	.clk(clk), .resetn(resetn), .mem_base(mem_base), .mem_req(mem_req), .mem_rsp(mem_rsp),
	.resume_detect(resume_detect), .frame_start(frame_start), .iso_desc_seen(iso_desc_seen),
	.control_served(control_served), .bulk_served(bulk_served), .core_irq(core_irq),
	.func_state(func_state), .bulk_list_go(bulk_list_go), .control_list_go(control_list_go),
	.periodic_go(periodic_go), .iso_skip(iso_skip), .bulk_turn(bulk_turn),
	.inta_req(inta_req), .smi_req(smi_req)
);

// ===== test/pci_host_model.sv
// Host processor model issuing single memory cycles
`timescale 1ns/1ns
module pci_host_model
(
	// Clock
	input wire logic                  clk,
	// Memory cycle request and answer
	output hc_ctrl_pkg::mem_req_t     mem_req,
	input wire hc_ctrl_pkg::mem_rsp_t mem_rsp
);
	initial mem_req = '0;
	// Released lines show inverted values so a late sample cannot pass by luck
	task automatic access(input logic w, input logic [31:0] a, input logic [3:0] be,
		input logic [31:0] d, output logic [31:0] q, output logic h, output logic v);
		@(negedge clk);
		mem_req = '{1'b1, w, a, be, d};
		@(posedge clk);
		@(negedge clk);
		mem_req = '{1'b0, ~w, ~a, ~be, ~d};
		q = mem_rsp.rdata;
		h = mem_rsp.hit;
		v = mem_rsp.valid;
	endtask
endmodule

// ===== test/usb_host_operational_control_regs_tb.sv
// Self-checking bench for the operation control register block
`timescale 1ns/1ns
module usb_host_operational_control_regs_tb;
	localparam logic [19:0] BASE = 20'hC0DE5;
	localparam logic [31:0] REV_A = {BASE, 12'h000};
	localparam logic [31:0] CTL = {BASE, 12'h004};
	localparam logic [31:0] REV = {24'h000000, hc_ctrl_pkg::REVISION_DEFAULT};
	logic                    clk = 1'b0;
	logic                    resetn = 1'b0;
	logic                    core_irq = 1'b0;
	logic [4:0]              ev = 5'h00;
	hc_ctrl_pkg::mem_req_t   req;
	hc_ctrl_pkg::mem_rsp_t   rsp;
	hc_ctrl_pkg::func_state_t fs;
	logic                    bl_go, ct_go, pe_go, iso_skip, turn, inta, smi;
	logic [31:0]             q;
	logic                    h, v;
	int                      errors = 0;
	int                      n_checks = 0;

	always #5 clk = ~clk;

	pci_host_model pci_host_model_i (.clk(clk), .mem_req(req), .mem_rsp(rsp));
	usb_host_operational_control_regs usb_host_operational_control_regs_i
	(
		.clk(clk), .resetn(resetn), .mem_base(BASE), .mem_req(req), .mem_rsp(rsp),
		.resume_detect(ev[4]), .frame_start(ev[2]), .iso_desc_seen(ev[3]),
		.control_served(ev[0]), .bulk_served(ev[1]), .core_irq(core_irq),
		.func_state(fs), .bulk_list_go(bl_go), .control_list_go(ct_go), .periodic_go(pe_go),
		.iso_skip(iso_skip), .bulk_turn(turn), .inta_req(inta), .smi_req(smi)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [3:0] be, input logic [31:0] d);
		pci_host_model_i.access(1'b1, a, be, d, q, h, v);
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic ehit);
		pci_host_model_i.access(1'b0, a, 4'h0, 32'h0, q, h, v);
		chk({30'h0, v, h}, {30'h0, 1'b1, ehit}, "read answer");
		chk(q, exp, "read data");
	endtask
	task automatic pulse(input int k);
		@(negedge clk);
		ev[k] = 1'b1;
		@(negedge clk);
		ev[k] = 1'b0;
	endtask

	task automatic t_lanes();
		rd(CTL, 32'h0, 1'b1);
		rd(REV_A, REV, 1'b1);
		wr(CTL, 4'hE, 32'hFFFF_FFFF);
		rd(CTL, 32'h0000_00FF, 1'b1);
		wr(CTL, 4'hD, 32'hFFFF_FF00);
		rd(CTL, 32'h0000_05FF, 1'b1);
		wr(CTL, 4'h3, 32'hFFFF_FFFF);
		rd(CTL, 32'h0000_05FF, 1'b1);
		wr(REV_A, 4'h0, 32'h0);
		rd(REV_A, REV, 1'b1);
		rd({BASE, 12'h008}, 32'h0, 1'b0);
		rd({~BASE, 12'h004}, 32'h0, 1'b0);
	endtask
	task automatic t_states();
		for (int s = 0; s < 4; s++)
		begin
			wr(CTL, 4'h0, 32'(s) << 6);
			chk(32'(fs), 32'(s), "state");
		end
		pulse(4);
		chk(32'(fs), 32'h1, "resume");
		wr(CTL, 4'h0, 32'h20);
		chk({30'h0, bl_go, ct_go}, 32'h2, "bulk go");
		wr(CTL, 4'h0, 32'h10);
		chk({30'h0, bl_go, ct_go}, 32'h1, "control go");
	endtask
	task automatic t_ratio();
		for (int r = 0; r < 4; r++)
		begin
			wr(CTL, 4'h0, 32'(r));
			repeat (r + 1)
			begin
				chk(32'(turn), 32'h0, "early turn");
				pulse(0);
			end
			// Extra control event while it is the bulk turn must be ignored
			pulse(0);
			chk(32'(turn), 32'h1, "turn");
			pulse(1);
			chk(32'(turn), 32'h0, "turn end");
		end
	endtask
	task automatic t_periodic();
		wr(CTL, 4'h0, 32'h04);
		chk(32'(pe_go), 32'h0, "before frame");
		pulse(2);
		chk(32'(pe_go), 32'h1, "frame sample");
		pulse(3);
		chk(32'(iso_skip), 32'h1, "iso skipped");
		wr(CTL, 4'h0, 32'h0C);
		pulse(3);
		chk(32'(iso_skip), 32'h0, "iso served");
	endtask
	task automatic t_irq();
		wr(CTL, 4'h0, 32'h0);
		core_irq = 1'b1;
		@(negedge clk);
		chk({30'h0, inta, smi}, 32'h2, "normal line");
		wr(CTL, 4'h0, 32'h100);
		@(negedge clk);
		chk({30'h0, inta, smi}, 32'h1, "smi line");
		core_irq = 1'b0;
	endtask
	task automatic t_reset();
		wr(CTL, 4'h0, 32'h0000_05FF);
		pulse(2);
		@(negedge clk);
		resetn = 1'b0;
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		chk({28'h0, fs, bl_go, ct_go}, 32'h0, "reset state");
		chk({28'h0, pe_go, turn, inta, smi}, 32'h0, "reset steering");
		rd(CTL, 32'h0, 1'b1);
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (20) @(negedge clk);
		resetn = 1'b1;
		t_lanes();
		t_states();
		t_ratio();
		t_periodic();
		t_irq();
		t_reset();
		end_of_test();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		errors++;
		$display("[FAIL] %0t run hung", $time);
		end_of_test();
	end
endmodule
